// file: src/ddr_io_cell.v
/*
  Double-data-rate I/O cell: output, output-enable and input register
  pairs with pin multiplexers, the input cascade into the slave cell, and
  an APB register file. Assumes the link clock and pin data arrive from
  outside pclk's domain and are far slower than pclk (edges found by
  sampling); the pin is split into input, output and output enable.
*/
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`include "ddr_io_cell_defs.vh"

// How it works
// R1 - output pair plus mux gives DDR output
// R2 - pair clocked by two complementary clocks
// R3 - local inverter derives second clock instead
// R4 - output enable pair switches on both edges
// R5 - input pair alternately captures on both clocks
// R6 - first bit primary rise, second secondary rise
// R7 - cascade re-registers second bit on primary
// R8 - cascade only with differential signal standard
// R9 - cascade path internal between paired cells
// R10 - without cascade user aligns second bit
// R11 - output first bit primary, second secondary
// R12 - user hands second bit to secondary domain
// R13 - DDR output can mirror a clock
// R14 - no edge alignment option exists
// R15 - clock manager makes 180 degree copy
// R16 - mux shows first bit high, second low
module ddr_io_cell #(
  parameter FIFO_DEPTH = `DDR_FIFO_DEPTH,
  parameter FIFO_AW = `DDR_FIFO_AW
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`DDR_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire clk_primary_pin,
  input wire clk_secondary_pin,
  input wire pad_in,
  output wire pad_out,
  output wire pad_oe
);
  localparam PW = `DDR_PAIR_W;

  // synchroniser stages: bit 0 primary clock, 1 secondary clock, 2 data
  wire [`DDR_SYNC_W-1:0] raw_in;
  reg [`DDR_SYNC_W-1:0] sync1_q;
  reg [`DDR_SYNC_W-1:0] sync2_q;
  reg prim_prev_q;
  reg sec_prev_q;

  reg [`DDR_CTRL_W-1:0] ctrl_q;
  reg [`DDR_STD_W-1:0] std_q;
  reg [`DDR_TX_W-1:0] tx_q;
  reg overflow_q;

  reg in_reg_a;
  reg in_reg_b;
  reg slave_reg_q;
  reg b_fresh_q;
  reg out_reg_a;
  reg out_reg_b;
  reg oe_reg_a;
  reg oe_reg_b;
  reg stage_b_q;
  reg stage_oe_b_q;

  wire prim_lvl;
  wire sec_lvl;
  wire prim_rise;
  wire sec_rise;
  wire is_diff;
  wire cascade_on;
  wire push_req;
  wire [PW-1:0] push_data;
  wire fifo_ready;
  wire [PW-1:0] fifo_data;
  wire fifo_valid;
  wire [FIFO_AW:0] fifo_level;
  wire stall;
  wire acc;
  wire setup;
  wire wr_en;
  wire addr_ok;
  wire rx_pop;
  reg [31:0] rd_mux;

  assign raw_in = {pad_in, clk_secondary_pin, clk_primary_pin};

  // two flops per pin; only the second stage feeds logic
  genvar gi;
  generate
    for (gi = 0; gi < `DDR_SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else if (ce) begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign prim_lvl = sync2_q[0];
  // R2 two lines: secondary taken from its own pin
  // R3 local inverter: secondary is the inverted primary
  assign sec_lvl = ctrl_q[`DDR_CTRL_TWO_LINES] ? sync2_q[1] : ~sync2_q[0];
  // R15 a clock manager's 180 degree copy arrives on the secondary pin
  assign prim_rise = prim_lvl & ~prim_prev_q;
  assign sec_rise = sec_lvl & ~sec_prev_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_prev_q <= 1'b0;
      // idle inverted primary is high; a low reset value would fake an edge
      sec_prev_q <= 1'b1;
    end else if (ce) begin
      prim_prev_q <= prim_lvl;
      sec_prev_q <= sec_lvl;
    end
  end

  // R8 cascade allowed only for differential standards
  assign is_diff = (std_q == `DDR_STD_LVDS) | (std_q == `DDR_STD_RSDS) |
                   (std_q == `DDR_STD_MINI_LVDS);
  assign cascade_on = ctrl_q[`DDR_CTRL_CASCADE] & is_diff;

  // R7 cascade pushes the aligned pair on the primary rise
  // R10 otherwise the pair is pushed as soon as the second bit lands
  assign push_req = ctrl_q[`DDR_CTRL_IN_EN] &
                    (cascade_on ? (prim_rise & b_fresh_q) : sec_rise);
  assign push_data = cascade_on ? {in_reg_a, in_reg_b} : {in_reg_a, sync2_q[2]};
  // a push refused by a full FIFO freezes capture that cycle; in cascade mode the held first bit is later pushed with a newer second bit
  assign stall = push_req & ~fifo_ready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reg_a <= 1'b0;
      in_reg_b <= 1'b0;
      slave_reg_q <= 1'b0;
      b_fresh_q <= 1'b0;
    end else if (ce && ctrl_q[`DDR_CTRL_IN_EN] && !stall) begin
      // R5 R6 first bit on primary rise
      if (prim_rise) begin
        in_reg_a <= sync2_q[2];
        // R7 R9 slave cell re-registers the second bit on primary
        slave_reg_q <= in_reg_b;
      end
      // R5 R6 second bit on secondary rise
      if (sec_rise) begin
        in_reg_b <= sync2_q[2];
      end
      if (sec_rise) begin
        b_fresh_q <= 1'b1;
      end else if (prim_rise) begin
        b_fresh_q <= 1'b0;
      end
    end
  end

  pair_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_data(push_data),
    .in_valid(push_req),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(rx_pop),
    .level(fifo_level)
  );

  // output side: R1 R11 first bit on primary, second on secondary
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg_a <= 1'b0;
      out_reg_b <= 1'b0;
      oe_reg_a <= 1'b0;
      oe_reg_b <= 1'b0;
      stage_b_q <= 1'b0;
      stage_oe_b_q <= 1'b0;
    end else if (ce) begin
      if (prim_rise) begin
        // R13 mirror mode drives 1 then 0, copying the clock
        out_reg_a <= ctrl_q[`DDR_CTRL_MIRROR] | tx_q[`DDR_TX_FIRST];
        // R4 enable pair follows the same scheme
        oe_reg_a <= ctrl_q[`DDR_CTRL_OUT_EN] & tx_q[`DDR_TX_OE_FIRST];
        // R12 second bits handed over in the primary domain
        stage_b_q <= ~ctrl_q[`DDR_CTRL_MIRROR] & tx_q[`DDR_TX_SECOND];
        stage_oe_b_q <= ctrl_q[`DDR_CTRL_OUT_EN] & tx_q[`DDR_TX_OE_SECOND];
      end
      // R14 plain pair, each flop on its own edge only
      if (sec_rise) begin
        out_reg_b <= stage_b_q;
        oe_reg_b <= stage_oe_b_q;
      end
    end
  end

  // R16 first bit while primary high, second while low
  assign pad_out = prim_lvl ? out_reg_a : out_reg_b;
  // R4 enable mux works like the data mux
  assign pad_oe = prim_lvl ? oe_reg_a : oe_reg_b;

  // APB slave, zero wait states while ce is high
  assign setup = psel & ~penable;
  assign acc = psel & penable & ce;
  assign wr_en = acc & pwrite;
  assign addr_ok = (paddr == `DDR_OFS_CTRL) | (paddr == `DDR_OFS_STD) |
                   (paddr == `DDR_OFS_TX) | (paddr == `DDR_OFS_RX) |
                   (paddr == `DDR_OFS_STATUS) | (paddr == `DDR_OFS_RAW);
  assign pready = ce;
  assign pslverr = psel & penable & ~addr_ok;
  // pop only what the setup-phase snapshot showed; a setup cycle with ce low loads none, so a stale valid bit can pop an unread word
  assign rx_pop = acc & ~pwrite & (paddr == `DDR_OFS_RX) & prdata[`DDR_RX_VALID];

  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `DDR_OFS_CTRL: rd_mux[`DDR_CTRL_W-1:0] = ctrl_q;
      `DDR_OFS_STD: rd_mux[`DDR_STD_W-1:0] = std_q;
      `DDR_OFS_TX: rd_mux[`DDR_TX_W-1:0] = tx_q;
      `DDR_OFS_RX: begin
        rd_mux[PW-1:0] = fifo_data & {PW{fifo_valid}};
        rd_mux[`DDR_RX_VALID] = fifo_valid;
      end
      `DDR_OFS_STATUS: begin
        rd_mux[`DDR_ST_CASCADE] = cascade_on;
        rd_mux[`DDR_ST_FULL] = ~fifo_ready;
        rd_mux[`DDR_ST_EMPTY] = ~fifo_valid;
        rd_mux[`DDR_ST_OVERFLOW] = overflow_q;
        rd_mux[`DDR_ST_LEVEL_LSB+FIFO_AW:`DDR_ST_LEVEL_LSB] = fifo_level;
      end
      // R10 raw pair for user logic doing its own alignment
      `DDR_OFS_RAW: rd_mux[2:0] = {slave_reg_q, in_reg_b, in_reg_a};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DDR_CTRL_RESET;
      std_q <= `DDR_STD_RESET;
      tx_q <= `DDR_TX_RESET;
      overflow_q <= 1'b0;
    end else if (ce) begin
      if (wr_en && paddr == `DDR_OFS_CTRL) begin
        ctrl_q <= pwdata[`DDR_CTRL_W-1:0];
      end
      if (wr_en && paddr == `DDR_OFS_STD) begin
        std_q <= pwdata[`DDR_STD_W-1:0];
      end
      if (wr_en && paddr == `DDR_OFS_TX) begin
        tx_q <= pwdata[`DDR_TX_W-1:0];
      end
      // a dropped capture in the clearing cycle still sets the flag
      if (stall) begin
        overflow_q <= 1'b1;
      end else if (wr_en && paddr == `DDR_OFS_STATUS && pwdata[`DDR_ST_OVERFLOW]) begin
        overflow_q <= 1'b0;
      end
    end
  end
endmodule

// file: include/ddr_io_cell_defs.vh
/*
  Register offsets, field positions, reset values and encodings for the
  double-data-rate I/O cell. Assumes a 32-bit APB bus with byte addresses.
*/
`ifndef DDR_IO_CELL_DEFS_VH
`define DDR_IO_CELL_DEFS_VH

`define DDR_ADDR_W 8
`define DDR_SYNC_W 3

`define DDR_OFS_CTRL 8'h00
`define DDR_OFS_STD 8'h04
`define DDR_OFS_TX 8'h08
`define DDR_OFS_RX 8'h0C
`define DDR_OFS_STATUS 8'h10
`define DDR_OFS_RAW 8'h14

`define DDR_CTRL_IN_EN 0
`define DDR_CTRL_CASCADE 1
`define DDR_CTRL_TWO_LINES 2
`define DDR_CTRL_MIRROR 3
`define DDR_CTRL_OUT_EN 4
`define DDR_CTRL_W 5
`define DDR_CTRL_RESET 5'h00

`define DDR_STD_W 2
`define DDR_STD_SINGLE 2'h0
`define DDR_STD_LVDS 2'h1
`define DDR_STD_RSDS 2'h2
`define DDR_STD_MINI_LVDS 2'h3
`define DDR_STD_RESET 2'h0

`define DDR_TX_FIRST 0
`define DDR_TX_SECOND 1
`define DDR_TX_OE_FIRST 2
`define DDR_TX_OE_SECOND 3
`define DDR_TX_W 4
`define DDR_TX_RESET 4'h0

`define DDR_RX_VALID 8
`define DDR_ST_CASCADE 0
`define DDR_ST_FULL 1
`define DDR_ST_EMPTY 2
`define DDR_ST_OVERFLOW 3
`define DDR_ST_LEVEL_LSB 8

`define DDR_FIFO_DEPTH 16
`define DDR_FIFO_AW 4
`define DDR_PAIR_W 2

`endif

// file: src/pair_fifo.v
/*
  Synchronous FIFO of flip-flops holding captured bit pairs.
  Assumes both sides run on pclk; ce low freezes all state.
*/
`timescale 1ns/10ps
module pair_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign level = cnt_q;
  assign push = in_valid & in_ready & ce;
  assign pop = out_valid & out_ready & ce;

  always @(posedge pclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// file: dv/ddr_io_cell_monitor.sv
/* Checker on the DDR I/O cell's ports.
   Bound from the bench; sees APB, ce and link pins only. */
`timescale 1ns/10ps
`include "ddr_io_cell_defs.vh"
module ddr_io_cell_monitor (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`DDR_ADDR_W-1:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire clk_primary_pin,
  input wire clk_secondary_pin,
  input wire pad_out,
  input wire pad_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_ce: assert property (pready == ce) else $error("pready not ce");
  a_err_phase: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  a_err_map: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > `DDR_OFS_RAW)) else $error("pslverr map");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
  a_rdata_load: assert property ($changed(prdata) |->
    $past(psel) && !$past(penable) && !$past(pwrite)) else $error("prdata moved");
  a_ce_freeze: assert property (!$past(ce) |-> $stable(pad_out) && $stable(pad_oe))
    else $error("pads moved in freeze");
  // sync delay is a few cycles, so eight quiet cycles leave the pads settled
  a_out_still:
    assert property ((ce && $stable(clk_primary_pin) && $stable(clk_secondary_pin))[*8]
    |=> $stable(pad_out)) else $error("pad_out moved");
  a_oe_still:
    assert property ((ce && !psel && $stable(clk_primary_pin) && $stable(clk_secondary_pin))[*8]
    |=> $stable(pad_oe)) else $error("pad_oe moved");
endmodule

// file: dv/link_partner.sv
/* Far-side DDR source: clock pair plus data, four periods per frame.
   Assumes go rises once per frame; pins stand still between frames. */
`timescale 1ns/10ps
module link_partner (
  input wire go,
  input wire [7:0] word,
  output reg clk_p,
  output reg clk_n,
  output reg din,
  output reg busy
);
  initial begin
    clk_p = 1'b0;
    clk_n = 1'b1;
    din = 1'b0;
    busy = 1'b0;
  end
  always @(posedge go) begin
    busy = 1'b1;
    #7;
    for (int k = 3; k >= 0; k--) begin
      din = word[2*k+1];
      #80;
      clk_p = 1'b1;
      clk_n = 1'b0;
      #80;
      din = word[2*k];
      #80;
      clk_p = 1'b0;
      clk_n = 1'b1;
      #80;
    end
    // undriven line: never leave the last bit showing
    din = ~din;
    busy = 1'b0;
  end
endmodule

// file: dv/ddr_io_cell_test.sv
/* Bench for the DDR I/O cell: APB master, link partner, scenarios.
   Assumes the partner drives the link pins and the checker is bound. */
`timescale 1ns/10ps
`include "ddr_io_cell_defs.vh"
module ddr_io_cell_test;
  reg pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg go = 1'b0, erv;
  reg [7:0] paddr = 8'h00, word = 8'h00;
  reg [31:0] pwdata = 32'h0, rdv;
  wire [31:0] prdata;
  wire pready, pslverr, clk_p, clk_n, din, busy, pad_out, pad_oe;
  int n_errors = 0, n_tests = 0, cyc = 0;
  ddr_io_cell u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_primary_pin(clk_p), .clk_secondary_pin(clk_n), .pad_in(din),
    .pad_out(pad_out), .pad_oe(pad_oe));
  link_partner u_link (.go(go), .word(word), .clk_p(clk_p), .clk_n(clk_n), .din(din),
    .busy(busy));
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      finish_test;
    end
  end
  task finish_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  task frame(input logic [7:0] w, input logic wait_end);
    word <= w;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    while (wait_end && busy === 1'b1) @(posedge pclk);
    if (wait_end) repeat (6) @(posedge pclk);
  endtask
  task t_regs;
    rd(`DDR_OFS_CTRL, 32'h0, "ctrl");
    rd(`DDR_OFS_TX, 32'h0, "tx");
    rd(`DDR_OFS_STATUS, 32'h4, "status");
    rd(8'h18, 32'h0, "unmapped");
    chk("unmapped err", 32'h1, erv);
  endtask
  task t_gate;
    apb(1'b1, `DDR_OFS_CTRL, 32'h2);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `DDR_OFS_STD, s);
      rd(`DDR_OFS_STATUS, 32'h4 | (s != 0), "cascade on");
    end
  endtask
  task t_rx;
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `DDR_OFS_CTRL, 32'h1 | (m << 2));
      frame(8'hB4, 1'b1);
      rd(`DDR_OFS_RAW, 32'h4, "raw");
      for (int k = 3; k >= 0; k--) rd(`DDR_OFS_RX, 32'h100 | ((32'hB4 >> 2*k) & 3), "pair");
      rd(`DDR_OFS_STATUS, 32'h4, "empty");
    end
  endtask
  task t_over;
    repeat (5) frame(8'h1B, 1'b1);
    rd(`DDR_OFS_STATUS, 32'h100A, "full");
    for (int i = 0; i < 16; i++) rd(`DDR_OFS_RX, 32'h100 | ((32'h1B >> (6 - 2*(i%4))) & 3), "fifo");
    apb(1'b1, `DDR_OFS_STATUS, 32'h8);
    apb(1'b0, `DDR_OFS_STATUS, 32'h0);
    chk("overflow clear", 32'h0, rdv & 32'h8);
  endtask
  task t_casc;
    logic [4:0] lvl;
    apb(1'b1, `DDR_OFS_CTRL, 32'h3);
    apb(1'b1, `DDR_OFS_STD, 32'h1);
    frame(8'h6C, 1'b1);
    apb(1'b0, `DDR_OFS_STATUS, 32'h0);
    lvl = rdv[12:8];
    // older pairs may sit ahead of this frame's three
    chk("cascade level", 32'h1, lvl >= 3 && lvl <= 6);
    repeat (lvl > 3 ? lvl - 3 : 0) apb(1'b0, `DDR_OFS_RX, 32'h0);
    for (int k = 3; k > 0; k--) rd(`DDR_OFS_RX, 32'h100 | ((32'h6C >> 2*k) & 3), "casc");
  endtask
  task t_tx;
    logic [15:0] cfg [4];
    logic [3:0] seen;
    cfg = '{16'h105A, 16'h18A9, 16'h14A5, 16'h00FC};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `DDR_OFS_CTRL, cfg[i][15:8]);
      apb(1'b1, `DDR_OFS_TX, cfg[i][7:4]);
      frame(8'h00, 1'b0);
      repeat (3) @(posedge clk_p);
      repeat (4) @(posedge pclk);
      #1 seen[3] = pad_out;
      seen[1] = pad_oe;
      @(negedge clk_p);
      repeat (4) @(posedge pclk);
      #1 seen[2] = pad_out;
      seen[0] = pad_oe;
      chk("pads", cfg[i][3:0], seen);
      ce <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("stall", 32'h0, pready);
      ce <= 1'b1;
      frame(8'h00, 1'b1);
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_gate;
    t_rx;
    t_over;
    t_casc;
    t_tx;
    finish_test;
  end
endmodule
bind ddr_io_cell ddr_io_cell_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .clk_primary_pin(clk_primary_pin),
  .clk_secondary_pin(clk_secondary_pin), .pad_out(pad_out), .pad_oe(pad_oe));
